// ==== hdl/rbs_pkg.sv ====
// Package: constants, timing counts and state type of the reset and boot sequencer
package rbs_pkg;
    // Clock rate of core_clk in MHz
    localparam int CLK_MHZ = 200;
    // Reset classification thresholds, in ns
    localparam int DIG_MIN_NS = 100;
    localparam int DIG_MAX_NS = 1000;
    localparam int ANA_MIN_NS = 10000;
    // Least times round up, longest round down
    localparam int DIG_MIN_CYC = (DIG_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int DIG_MAX_CYC = (DIG_MAX_NS * CLK_MHZ) / 1000;
    localparam int ANA_MIN_CYC = (ANA_MIN_NS * CLK_MHZ + 999) / 1000;
    // PLL start and power-up boot delay, in us
    localparam int PLL_START_US = 3000;
    localparam int PLL_START_CYC = PLL_START_US * CLK_MHZ;
    // Width of the low-time counter
    localparam int LOW_CNT_W = 16;
    // Width of the boot wait counter
    localparam int WAIT_CNT_W = 24;
    // Strap field positions
    localparam int STRAP_W = 3;
    localparam int STRAP_FS_LO = 0;
    localparam int STRAP_FS_HI = 1;
    localparam int STRAP_BOOT = 2;
    // Strap reset value
    localparam logic [2:0] STRAP_RST = 3'h0;
    // Clock / frame-sync source codes
    localparam logic [1:0] CLKSRC_REF12 = 2'h0;
    localparam logic [1:0] CLKSRC_FS8K = 2'h1;
    localparam logic [1:0] CLKSRC_FS16K = 2'h2;
    localparam logic [1:0] CLKSRC_RSVD = 2'h3;
    // Host port mode codes
    localparam logic HOST_MODE_TWI = 1'h0;
    localparam logic HOST_MODE_SPI = 1'h1;
    // Host serial clock edges that switch the port to serial peripheral mode
    localparam logic [1:0] SPI_DETECT_EDGES = 2'h2;
    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        RBS_RESET = 7'h01,
        RBS_PLL_WAIT = 7'h02,
        RBS_SENSE = 7'h04,
        RBS_FLASH_LOAD = 7'h08,
        RBS_CONFIG = 7'h10,
        RBS_HOST_WAIT = 7'h20,
        RBS_RUN = 7'h40
    } rbs_state_t;
endpackage

// ==== hdl/rbs_sequencer.sv ====
// Reset-length classifier, core supply control and boot sequencer
`default_nettype none
module rbs_sequencer #(
    parameter int PLL_START_CYCLES = rbs_pkg::PLL_START_CYC
) (
    // Clock and power-on reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Reset pin and supply select pin
    input wire logic reset_pin_n,
    input wire logic supply_source_select,
    // Strap pins, after the internal pull-downs
    input wire logic [rbs_pkg::STRAP_W-1:0] strap_pins,
    // Host port serial clock pin
    input wire logic host_sclk,
    // Loader handshakes
    input wire logic flash_load_done,
    input wire logic host_load_done,
    input wire logic firmware_swap_req,
    // Supply and PLL control
    output logic core_supply_enable_out,
    output logic regulator_gate_mode,
    output logic pll_enable,
    // Digital reset to the rest of the device
    output logic core_reset_n,
    // Boot status and decoded straps
    output logic [rbs_pkg::STRAP_W-1:0] boot_sense,
    output logic [1:0] clock_source_sel,
    output logic flash_boot_sel,
    output logic flash_load_start,
    output logic flash_chip_select_on_gpio9,
    output logic strap_pins_released,
    output logic config_defaults_load,
    output logic jump_to_firmware,
    output logic host_wait,
    output logic host_slave_port,
    output logic host_interrupt_n
);
    import rbs_pkg::*;

    // Complete state of the block
    typedef struct packed {
        // Reset pin synchroniser, stage 0 nearest the pin
        logic [2:0] rst_sync;
        // Host clock synchroniser
        logic [2:0] sclk_sync;
        // Filtered host clock level
        logic sclk_level;
        // Filtered reset pin level, high while the pin is held low
        logic rst_low;
        // Cycles the filtered pin has been low
        logic [LOW_CNT_W-1:0] low_cnt;
        // Long reset seen; supply and PLL off while it is held
        logic analog;
        // PLL start wait counter
        logic [WAIT_CNT_W-1:0] wait_cnt;
        // Boot sequencer state
        rbs_state_t state;
        // Boot sense store of the straps
        logic [STRAP_W-1:0] sense;
        // Rising host clock edges seen since reset
        logic [1:0] edges;
        // Host port mode
        logic host_spi;
        // Host interrupt, active low
        logic irq_n;
        // One-cycle pulses to the loader
        logic flash_start;
        logic cfg_load;
        logic jump;
    } rbs_regs_t;

    rbs_regs_t s_q;
    rbs_regs_t s_d;

    // Decode the low strap bits into a source code
    function automatic logic [1:0] rbs_decode_src(input logic [STRAP_W-1:0] st);
        logic [1:0] r;
        r = CLKSRC_RSVD;
        case ({st[STRAP_FS_HI], st[STRAP_FS_LO]})
            2'h0: r = CLKSRC_REF12;
            2'h1: r = CLKSRC_FS8K;
            2'h2: r = CLKSRC_FS16K;
            default: r = CLKSRC_RSVD;
        endcase
        return r;
    endfunction

    // Next-state logic
    always_comb
    begin
        logic rst_pin_low;
        logic sclk_rise;
        logic rst_rise;
        rst_pin_low = 1'b0;
        sclk_rise = 1'b0;
        rst_rise = 1'b0;
        // Hold everything by default; pulses last one cycle
        s_d = s_q;
        s_d.flash_start = 1'b0;
        s_d.cfg_load = 1'b0;
        s_d.jump = 1'b0;
        // Three-stage synchronisers; change counts when stages 2 and 3 agree
        s_d.rst_sync = {s_q.rst_sync[1:0], reset_pin_n};
        s_d.sclk_sync = {s_q.sclk_sync[1:0], host_sclk};
        if (s_q.rst_sync[1] == s_q.rst_sync[2])
        begin
            s_d.rst_low = ~s_q.rst_sync[2];
        end
        rst_pin_low = s_d.rst_low;
        rst_rise = s_q.rst_low && !rst_pin_low;
        // Host clock level follows once stages 2 and 3 agree
        if (s_q.sclk_sync[1] == s_q.sclk_sync[2])
        begin
            s_d.sclk_level = s_q.sclk_sync[2];
        end
        sclk_rise = s_d.sclk_level && !s_q.sclk_level;
        if (rst_pin_low)
        begin
            // A new low period starts unclassified, so a short pulse never drops the supply
            if (!s_q.rst_low)
            begin
                s_d.analog = 1'b0;
            end
            // Measure the low time and classify the reset
            if (s_q.low_cnt != {LOW_CNT_W{1'b1}})
            begin
                s_d.low_cnt = s_q.low_cnt + LOW_CNT_W'(1);
            end
            if (s_q.low_cnt >= LOW_CNT_W'(ANA_MIN_CYC - 1))
            begin
                s_d.analog = 1'b1;
            end
            // Every state returns to reset while the pin is low
            s_d.state = RBS_RESET;
            s_d.sense = STRAP_RST;
            s_d.edges = 2'h0;
            s_d.host_spi = HOST_MODE_TWI;
            s_d.irq_n = 1'b1;
            s_d.wait_cnt = '0;
        end
        else
        begin
            s_d.low_cnt = '0;
            case (s_q.state)
                RBS_RESET:
                begin
                    // Any release, digital or analog, reboots fully
                    if (rst_rise || !s_q.rst_low)
                    begin
                        s_d.state = RBS_PLL_WAIT;
                        s_d.wait_cnt = '0;
                    end
                end
                RBS_PLL_WAIT:
                begin
                    // Wait for PLL start after every reset type, so the clocks are settled
                    if (s_q.wait_cnt >= WAIT_CNT_W'(PLL_START_CYCLES - 1))
                    begin
                        s_d.state = RBS_SENSE;
                        s_d.analog = 1'b0;
                        s_d.irq_n = 1'b0;
                    end
                    else
                    begin
                        s_d.wait_cnt = s_q.wait_cnt + WAIT_CNT_W'(1);
                    end
                end
                RBS_SENSE:
                begin
                    // Capture straps into the boot sense store
                    s_d.sense = strap_pins;
                    // Third strap bit picks flash or host as load source
                    if (strap_pins[STRAP_BOOT])
                    begin
                        s_d.state = RBS_FLASH_LOAD;
                        s_d.flash_start = 1'b1;
                    end
                    else
                    begin
                        s_d.state = RBS_HOST_WAIT;
                    end
                end
                RBS_FLASH_LOAD:
                begin
                    // Image and record copy runs until the loader reports done
                    if (flash_load_done)
                    begin
                        s_d.state = RBS_CONFIG;
                        s_d.cfg_load = 1'b1;
                    end
                end
                RBS_CONFIG:
                begin
                    // Defaults are set; jump to the loaded firmware next
                    s_d.state = RBS_RUN;
                    s_d.jump = 1'b1;
                end
                RBS_HOST_WAIT:
                begin
                    // Idle until the host has written program memory
                    if (host_load_done)
                    begin
                        s_d.state = RBS_RUN;
                    end
                end
                RBS_RUN:
                begin
                    // A firmware swap returns to the host wait
                    if (firmware_swap_req)
                    begin
                        s_d.state = RBS_HOST_WAIT;
                    end
                end
                default:
                begin
                    // Illegal code recovers through reset
                    s_d.state = RBS_RESET;
                end
            endcase
            // Host port mode detection from serial clock edges
            if (sclk_rise && s_q.edges != SPI_DETECT_EDGES)
            begin
                s_d.edges = s_q.edges + 2'h1;
            end
            if (s_d.edges == SPI_DETECT_EDGES)
            begin
                s_d.host_spi = HOST_MODE_SPI;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{rst_sync: 3'h0, sclk_sync: 3'h0, sclk_level: 1'b0, rst_low: 1'b1,
                     low_cnt: '0,
                     analog: 1'b1, wait_cnt: '0, state: RBS_RESET, sense: STRAP_RST,
                     edges: 2'h0, host_spi: HOST_MODE_TWI, irq_n: 1'b1,
                     flash_start: 1'b0, cfg_load: 1'b0, jump: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Supply enable low only while a long reset is held
    assign core_supply_enable_out = !(s_q.analog && s_q.rst_low);
    assign pll_enable = !(s_q.analog && s_q.rst_low);
    // Select low: the enable is the regulator transistor gate drive
    assign regulator_gate_mode = !supply_source_select;
    // Core held in reset until firmware runs or the host wait begins
    assign core_reset_n = (s_q.state == RBS_RUN) || (s_q.state == RBS_HOST_WAIT);
    // Boot sense store and its decode
    assign boot_sense = s_q.sense;
    assign clock_source_sel = rbs_decode_src(s_q.sense);
    assign flash_boot_sel = s_q.sense[STRAP_BOOT];
    // Loader start pulse
    assign flash_load_start = s_q.flash_start;
    // GPIO 9 serves as flash chip select once a flash boot is chosen
    assign flash_chip_select_on_gpio9 = s_q.sense[STRAP_BOOT] &&
        (s_q.state != RBS_RESET) && (s_q.state != RBS_PLL_WAIT) &&
        (s_q.state != RBS_SENSE);
    // Strap pins free for other functions once sensing is over
    assign strap_pins_released = (s_q.state != RBS_RESET) &&
        (s_q.state != RBS_PLL_WAIT) && (s_q.state != RBS_SENSE);
    // Configuration and jump pulses
    assign config_defaults_load = s_q.cfg_load;
    assign jump_to_firmware = s_q.jump;
    // Host side status
    assign host_wait = (s_q.state == RBS_HOST_WAIT);
    assign host_slave_port = s_q.host_spi;
    assign host_interrupt_n = s_q.irq_n;
endmodule
`default_nettype wire

// ==== bench/rbs_sequencer_properties.sv ====
// Checker of supply, reset-length and boot relations at the sequencer ports
`default_nettype none
module rbs_seq_props #(
    parameter int PLL_START_CYCLES = 20
) (
    // Clock, reset and pins
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reset_pin_n,
    input wire logic supply_source_select,
    // Watched outputs
    input wire logic core_supply_enable_out,
    input wire logic regulator_gate_mode,
    input wire logic pll_enable,
    input wire logic core_reset_n,
    input wire logic host_interrupt_n,
    input wire logic [rbs_pkg::STRAP_W-1:0] boot_sense,
    input wire logic [1:0] clock_source_sel,
    input wire logic flash_boot_sel,
    input wire logic config_defaults_load,
    input wire logic jump_to_firmware
);
    timeunit 1ns;
    timeprecision 1ps;
    import rbs_pkg::*;
    // Cycles the raw pin has stayed low, and high
    logic [15:0] low_q;
    logic [23:0] high_q;
    // Run lengths of the pin, saturating so they never wrap
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_q <= 16'h0;
            high_q <= 24'h0;
        end
        else
        begin
            low_q <= reset_pin_n ? 16'h0 : low_q + {15'h0, ~&low_q};
            high_q <= reset_pin_n ? high_q + {23'h0, ~&high_q} : 24'h0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_pll; pll_enable == core_supply_enable_out; endproperty
    a_pll: assert property (p_pll) else $error("pll enable mismatch");
    property p_gate; regulator_gate_mode == !supply_source_select; endproperty
    a_gate: assert property (p_gate) else $error("gate mode mismatch");
    property p_drop; $fell(core_supply_enable_out) |-> low_q inside {[16'h7CB:16'h7DA]}; endproperty
    a_drop: assert property (p_drop) else $error("supply dropped early");
    property p_back; $rose(reset_pin_n) |-> ##[1:6] core_supply_enable_out; endproperty
    a_back: assert property (p_back) else $error("supply not back");
    property p_held; !reset_pin_n [*5] |-> !core_reset_n; endproperty
    a_held: assert property (p_held) else $error("core left running");
    property p_wait; $fell(host_interrupt_n) |-> high_q >= PLL_START_CYCLES; endproperty
    a_wait: assert property (p_wait) else $error("boot before pll");
    property p_dec; core_reset_n |-> {flash_boot_sel, clock_source_sel} == boot_sense; endproperty
    a_dec: assert property (p_dec) else $error("strap decode");
    property p_keep; core_reset_n && $past(core_reset_n) |-> $stable(boot_sense); endproperty
    a_keep: assert property (p_keep) else $error("sense changed");
    property p_jump; config_defaults_load |=> jump_to_firmware; endproperty
    a_jump: assert property (p_jump) else $error("no jump");
endmodule
bind rbs_sequencer rbs_seq_props #(.PLL_START_CYCLES(PLL_START_CYCLES)) u_props (
    .core_clk, .rst_n, .reset_pin_n, .supply_source_select, .core_supply_enable_out,
    .regulator_gate_mode, .pll_enable, .core_reset_n, .host_interrupt_n, .boot_sense,
    .clock_source_sel, .flash_boot_sel, .config_defaults_load, .jump_to_firmware);
`default_nettype wire

// ==== bench/rbs_host_model.sv ====
// Model of the reset driver and host processor beside the sequencer
`default_nettype none
module rbs_host_model (
    // Bench clock
    input wire logic core_clk,
    // Reset pin, host clock and download handshake
    output var logic reset_pin_n,
    output var logic host_sclk,
    output var logic host_load_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: reset released, host clock still
    initial
    begin
        reset_pin_n = 1'h1;
        host_sclk = 1'h0;
        host_load_done = 1'h0;
    end
    // Reset low for n cycles; reference kept running meanwhile
    task automatic pulse(input int n);
        reset_pin_n <= 1'h0;
        repeat (n) @(posedge core_clk);
        reset_pin_n <= 1'h1;
    endtask
    // Serial peripheral host: periods of 8 cycles (25 MHz);
    // two-wire host (one period only): 500 cycles (400 kHz)
    task automatic clocks(input int n);
        int half;
        half = (n < 2) ? 250 : 4;
        repeat (n)
        begin
            host_sclk <= 1'h1;
            repeat (half) @(posedge core_clk);
            host_sclk <= 1'h0;
            repeat (half) @(posedge core_clk);
        end
    endtask
    // End of a host download, one cycle
    task automatic load();
        host_load_done <= 1'h1;
        @(posedge core_clk);
        host_load_done <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ==== bench/rbs_sequencer_tb_top.sv ====
// Self-checking bench of the reset, supply and boot sequencer
`default_nettype none
module rbs_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rbs_pkg::*;
    localparam int PLL_CYC = 20;
    // Bench-driven pins
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic supply_source_select = 1'h0;
    logic [STRAP_W-1:0] strap_pins = 3'h0;
    logic flash_load_done = 1'h0;
    logic firmware_swap_req = 1'h0;
    wire logic reset_pin_n, host_sclk, host_load_done;
    // Design outputs
    logic core_supply_enable_out, regulator_gate_mode, pll_enable, core_reset_n;
    logic [STRAP_W-1:0] boot_sense;
    logic [1:0] clock_source_sel;
    logic flash_boot_sel, flash_load_start, flash_chip_select_on_gpio9, strap_pins_released;
    logic config_defaults_load, jump_to_firmware, host_wait, host_slave_port, host_interrupt_n;
    int err_count = 0;
    int total_checks = 0;
    int seed = 69;
    // Model queue of the straps applied for each boot
    logic [2:0] sense_q[$];
    always #2.5 core_clk = ~core_clk;
    rbs_sequencer #(.PLL_START_CYCLES(PLL_CYC)) DUT (.core_clk, .rst_n, .reset_pin_n,
        .supply_source_select, .strap_pins, .host_sclk, .flash_load_done, .host_load_done,
        .firmware_swap_req, .core_supply_enable_out, .regulator_gate_mode, .pll_enable,
        .core_reset_n, .boot_sense, .clock_source_sel, .flash_boot_sel, .flash_load_start,
        .flash_chip_select_on_gpio9, .strap_pins_released, .config_defaults_load,
        .jump_to_firmware, .host_wait, .host_slave_port, .host_interrupt_n);
    rbs_host_model u_host (.core_clk, .reset_pin_n, .host_sclk, .host_load_done);
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Compare a 3-bit result with the model
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Model of the strap decode into clock-source codes
    function automatic logic [1:0] model_src(input logic [2:0] st);
        case (st[1:0])
            2'h0: return CLKSRC_REF12;
            2'h1: return CLKSRC_FS8K;
            2'h2: return CLKSRC_FS16K;
            default: return CLKSRC_RSVD;
        endcase
    endfunction
    // Design event selected by w
    function automatic logic pick(input int w);
        case (w)
            0: return !host_interrupt_n;
            1: return flash_load_start;
            2: return jump_to_firmware;
            default: return host_wait;
        endcase
    endfunction
    // Bounded wait for an event; n returns the cycles taken
    task automatic wait_on(input int w, output int n);
        for (n = 1; n < 5000; n++)
        begin
            @(posedge core_clk);
            #1;
            if (pick(w) === 1'h1)
                return;
        end
        err_count++;
        $display("wrong value at %0t: wait ran out", $time);
        complete_run();
    endtask
    // Reset of low cycles with random straps and supply mode, then full boot
    task automatic boot(input int low);
        int n;
        logic [2:0] s;
        logic g;
        logic sup;
        s = 3'($random(seed));
        g = 1'($random(seed));
        sup = low < ANA_MIN_CYC;
        @(posedge core_clk);
        strap_pins <= s;
        supply_source_select <= g;
        sense_q.push_back(s);
        u_host.pulse(low);
        #1;
        chk({2'h0, core_supply_enable_out}, {2'h0, sup});
        chk({2'h0, pll_enable}, {2'h0, sup});
        chk({2'h0, regulator_gate_mode}, {2'h0, !g});
        wait_on(0, n);
        chk({2'h0, n >= PLL_CYC + 3 && n <= PLL_CYC + 8}, 3'h1);
        wait_on(s[2] ? 1 : 3, n);
        chk(boot_sense, sense_q[0]);
        chk({1'h0, clock_source_sel}, {1'h0, model_src(sense_q[0])});
        chk({2'h0, flash_boot_sel}, {2'h0, sense_q[0][2]});
        chk({2'h0, flash_chip_select_on_gpio9}, {2'h0, sense_q[0][2]});
        chk({2'h0, strap_pins_released}, 3'h1);
        @(posedge core_clk);
        strap_pins <= ~s;
        if (s[2])
        begin
            repeat (s * 3 + 1) @(posedge core_clk);
            flash_load_done <= 1'h1;
            @(posedge core_clk);
            flash_load_done <= 1'h0;
            #1;
            chk({2'h0, config_defaults_load}, 3'h1);
            wait_on(2, n);
            chk({2'h0, n == 1}, 3'h1);
            chk({2'h0, core_reset_n}, 3'h1);
        end
        else
        begin
            u_host.clocks(s[0] + 1);
            #1;
            chk({2'h0, host_slave_port}, {2'h0, s[0]});
            @(posedge core_clk);
            u_host.load();
            repeat (3) @(posedge core_clk);
            #1;
            chk({2'h0, host_wait}, 3'h0);
        end
        chk(boot_sense, sense_q.pop_front());
    endtask
    // Power-up boot, resets of every class, then a firmware swap
    initial
    begin
        int n;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'h1;
        wait_on(3, n);
        chk(boot_sense, 3'h0);
        @(posedge core_clk);
        u_host.load();
        for (int i = 0; i < 15; i++)
            boot(i % 3 == 0 ? 2100 : (i % 3 == 1 ? 20 + i : 300 + i * 100));
        @(posedge core_clk);
        firmware_swap_req <= 1'h1;
        wait_on(3, n);
        chk({2'h0, host_wait}, 3'h1);
        @(posedge core_clk);
        firmware_swap_req <= 1'h0;
        complete_run();
    end
endmodule
`default_nettype wire
